// file: core/bsc_commutator.sv
`timescale 1ns/1ps
module bsc_commutator #(
  parameter int TIMEOUT_CYC = bsc_pkg::TIMEOUT_CYC,
  parameter int CW          = bsc_pkg::CNT_W,
  parameter int DW          = bsc_pkg::DUTY_W
) (
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  input  wire logic          ce_i,
  // control
  input  wire logic          enable_i,
  input  wire logic          sensorless_i,
  input  wire logic [DW-1:0] duty_i,
  // position inputs
  input  wire logic [2:0]    hall_i,
  input  wire logic [2:0]    bemf_cmp_i,
  // bridge and status
  output bsc_pkg::bsc_bridge_t bridge_o,
  output logic [2:0]         sector_o,
  output logic               running_o,
  output logic               zc_o
);

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} bsc_state_t;

  // ---------------------------------------------------------------
  // pwm source
  // ---------------------------------------------------------------
  logic pwm;

  bsc_pwm #(.W(DW)) u_pwm (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .duty_i (duty_i),
    .pwm_o  (pwm)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  bsc_state_t          state;
  bsc_state_t          next_state;
  logic [2:0]          hall_q;
  logic [2:0]          next_sector;
  logic                next_running;
  logic                next_zc;
  bsc_pkg::bsc_bridge_t next_bridge;
  logic [CW-1:0]       period_cnt;
  logic [CW-1:0]       next_period_cnt;
  logic [CW-1:0]       period_last;
  logic [CW-1:0]       next_period_last;
  logic [CW-1:0]       delay_cnt;
  logic [CW-1:0]       next_delay_cnt;
  logic                delay_act;
  logic                next_delay_act;
  logic                armed;
  logic                next_armed;
  bsc_pkg::bsc_hall_t  hd;
  logic                flt_cmp;
  logic                target;
  logic                commutate;
  logic [2:0]          sector_inc;

  always_comb
  begin
    hd               = bsc_pkg::decode(hall_q);
    // sectors 0, 2, 4 see a falling floating lead, sectors 1, 3, 5 a rising one
    target           = sector_o[0];
    flt_cmp          = |(bemf_cmp_i & bsc_pkg::float_lead(sector_o));
    sector_inc       = (sector_o == bsc_pkg::SECTOR_MAX) ? bsc_pkg::SECTOR_RST
                                                         : sector_o + 3'h1;
    next_state       = state;
    next_sector      = sector_o;
    next_zc          = 1'b0;
    next_period_cnt  = period_cnt;
    next_period_last = period_last;
    next_delay_cnt   = delay_cnt;
    next_delay_act   = delay_act;
    next_armed       = armed;
    commutate        = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_sector     = bsc_pkg::SECTOR_RST;
        next_period_cnt = '0;
        next_delay_act  = 1'b0;
        next_armed      = 1'b0;
        if (enable_i)
        begin
          next_state = ST_RUN;
          if (!sensorless_i && hd.valid)
          begin
            next_sector = hd.sector;
          end
        end
      end
      ST_RUN:
      begin
        if (!enable_i)
        begin
          next_state = ST_IDLE;
        end
        else if (!sensorless_i)
        begin
          // invalid codes leave the sector untouched
          if (hd.valid)
          begin
            next_sector = hd.sector;
          end
        end
        else
        begin
          next_period_cnt = period_cnt + CW'(1);
          // blanking skips the demagnetising spike after each commutation
          if (period_cnt == CW'(bsc_pkg::BLANK_CYC) && flt_cmp != target)
          begin
            next_armed = 1'b1;
          end
          // a crossing in the timeout cycle is dropped: the forced step wins
          if (armed && !delay_act && flt_cmp == target
              && period_cnt != CW'(TIMEOUT_CYC - 1))
          begin
            // half a 60-degree sector is 30 degrees
            next_zc        = 1'b1;
            next_armed     = 1'b0;
            next_delay_act = 1'b1;
            next_delay_cnt = (period_last >> 1) | CW'(1);
          end
          if (delay_act)
          begin
            next_delay_cnt = delay_cnt - CW'(1);
            commutate      = (delay_cnt == CW'(1));
          end
          // no step by the timeout cycle, even with a zero-cross delay still running: step anyway so a stalled rotor is retried
          if (period_cnt == CW'(TIMEOUT_CYC - 1))
          begin
            commutate = 1'b1;
          end
          if (commutate)
          begin
            next_sector      = sector_inc;
            next_period_last = period_cnt + CW'(1);
            next_period_cnt  = '0;
            next_delay_act   = 1'b0;
            next_armed       = 1'b0;
          end
        end
      end
    endcase
    next_running = (next_state == ST_RUN);
    next_bridge  = (state == ST_RUN) ? bsc_pkg::pattern(sector_o, pwm)
                                     : bsc_pkg::BRIDGE_OFF;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state       <= ST_IDLE;
      hall_q      <= 3'h0;
      sector_o    <= bsc_pkg::SECTOR_RST;
      running_o   <= 1'b0;
      zc_o        <= 1'b0;
      bridge_o    <= bsc_pkg::BRIDGE_OFF;
      period_cnt  <= '0;
      period_last <= CW'(TIMEOUT_CYC);
      delay_cnt   <= '0;
      delay_act   <= 1'b0;
      armed       <= 1'b0;
    end
    else if (ce_i)
    begin
      state       <= next_state;
      hall_q      <= hall_i;
      sector_o    <= next_sector;
      running_o   <= next_running;
      zc_o        <= next_zc;
      bridge_o    <= next_bridge;
      period_cnt  <= next_period_cnt;
      period_last <= next_period_last;
      delay_cnt   <= next_delay_cnt;
      delay_act   <= next_delay_act;
      armed       <= next_armed;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  chk_two_driven: assert property (
    ($countones(bridge_o.ls) == 1) || (bridge_o.ls == 3'h0 && bridge_o.hs == 3'h0))
    else $error("low side not one-hot");
  chk_no_overlap: assert property (
    (bridge_o.hs & bridge_o.ls) == 3'h0)
    else $error("high and low side on together");
  chk_idle_off: assert property (
    ce_i && !running_o |=> bridge_o == bsc_pkg::BRIDGE_OFF)
    else $error("bridge driven while idle");
  chk_pattern_map: assert property (
    ce_i && running_o |=> bridge_o.ls == bsc_pkg::pattern($past(sector_o), 1'b1).ls)
    else $error("low side does not match sector");
  chk_pwm_gate: assert property (
    ce_i && !pwm |=> bridge_o.hs == 3'h0)
    else $error("high side on with pwm low");
  chk_hall_follow: assert property (
    (ce_i && running_o && !sensorless_i && enable_i && bsc_pkg::decode(hall_i).valid)
      ##1 (ce_i && enable_i && $stable(hall_i))
      |=> sector_o == bsc_pkg::decode($past(hall_i, 2)).sector)
    else $error("sector not decoded from halls");
  chk_invalid_hold: assert property (
    ce_i && running_o && !sensorless_i && enable_i && !bsc_pkg::decode(hall_q).valid
      |=> $stable(sector_o))
    else $error("sector moved on invalid hall code");
  chk_sector_order: assert property (
    ce_i && running_o && sensorless_i && enable_i && commutate
      |=> sector_o == $past(sector_inc))
    else $error("sensorless step out of order");
  chk_zc_delay: assert property (
    ce_i && next_zc |=> delay_act && delay_cnt == (($past(period_last) >> 1) | CW'(1)))
    else $error("commutation delay not half a sector");

  cov_sensored_run: cover property (running_o && !sensorless_i && $changed(sector_o));
  cov_zero_cross:   cover property (zc_o);
  cov_wrap:         cover property (sector_o == 3'h5 ##1 sector_o == 3'h0);
  cov_disable:      cover property (running_o ##1 !running_o);

endmodule

// file: core/bsc_pkg.sv
package bsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int CLK_NS         = 40;
  localparam int MAX_ERPM       = 100_000;
  localparam int SECTORS        = 6;
  // shortest sector at top speed, in clock cycles (2500)
  localparam int MIN_SECTOR_CYC = CLK_HZ * 60 / (MAX_ERPM * SECTORS);
  localparam int BLANK_NS       = 2000;
  localparam int BLANK_CYC      = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_MS     = 40;
  localparam int TIMEOUT_CYC    = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int CNT_W          = 21;
  localparam int DUTY_W         = 8;

  // ---------------------------------------------------------------
  // sector reset value and last sector
  // ---------------------------------------------------------------
  localparam logic [2:0] SECTOR_RST = 3'h0;
  localparam logic [2:0] SECTOR_MAX = 3'h5;

  // lead 0 red, lead 1 green, lead 2 blue
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } bsc_bridge_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] sector;
  } bsc_hall_t;

  localparam bsc_bridge_t BRIDGE_OFF = '{hs: 3'h0, ls: 3'h0};

  // high side carries the pwm, low side is held on for the whole sector
  function automatic bsc_bridge_t pattern(input logic [2:0] s, input logic pwm);
    bsc_bridge_t b;
    b = BRIDGE_OFF;
    unique case (s)
      3'h0:    begin b.hs = 3'h1; b.ls = 3'h2; end
      3'h1:    begin b.hs = 3'h1; b.ls = 3'h4; end
      3'h2:    begin b.hs = 3'h2; b.ls = 3'h4; end
      3'h3:    begin b.hs = 3'h2; b.ls = 3'h1; end
      3'h4:    begin b.hs = 3'h4; b.ls = 3'h1; end
      3'h5:    begin b.hs = 3'h4; b.ls = 3'h2; end
      default: b = BRIDGE_OFF;
    endcase
    if (!pwm)
    begin
      b.hs = 3'h0;
    end
    return b;
  endfunction

  // hall bit 0 = sensor a, bit 1 = b, bit 2 = c; 000 and 111 decode invalid
  function automatic bsc_hall_t decode(input logic [2:0] h);
    bsc_hall_t d;
    d.valid = 1'b1;
    unique case (h)
      3'h5:    d.sector = 3'h0;
      3'h1:    d.sector = 3'h1;
      3'h3:    d.sector = 3'h2;
      3'h2:    d.sector = 3'h3;
      3'h6:    d.sector = 3'h4;
      3'h4:    d.sector = 3'h5;
      default: begin d.sector = 3'h0; d.valid = 1'b0; end
    endcase
    return d;
  endfunction

  // undriven lead as a one-hot mask
  function automatic logic [2:0] float_lead(input logic [2:0] s);
    bsc_bridge_t b;
    b = pattern(s, 1'b1);
    return ~(b.hs | b.ls);
  endfunction

endpackage

// file: core/bsc_pwm.sv
`timescale 1ns/1ps
module bsc_pwm #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  // duty
  input  wire logic [W-1:0] duty_i,
  output logic              pwm_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_pwm;

  always_comb
  begin
    next_cnt = cnt + W'(1);
    next_pwm = (cnt < duty_i);
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt   <= '0;
      pwm_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt   <= next_cnt;
      pwm_o <= next_pwm;
    end
  end

endmodule

// file: tb/bsc_motor_model.sv
`timescale 1ns/1ps
module bsc_motor_model (
  // rotor position and fault injection from the bench
  input  wire logic [2:0] pos_i,
  input  wire logic       bad_i,
  input  wire logic [2:0] bad_code_i,
  // sensor lines
  output logic [2:0]      hall_o
);
  // ---------------------------------------------------------------
  // hall sensors
  // ---------------------------------------------------------------
  // a broken sensor harness is only shown when the bench asks for it
  always_comb
  begin
    hall_o[0] = (pos_i < 3'h3);
    hall_o[1] = (pos_i >= 3'h2) && (pos_i <= 3'h4);
    hall_o[2] = (pos_i == 3'h0) || (pos_i >= 3'h4);
    if (bad_i)
    begin
      hall_o = bad_code_i;
    end
  end
endmodule

// file: tb/bsc_commutator_tb_top.sv
`timescale 1ns/1ps
module bsc_commutator_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int TO = 2000;
  logic                 mclk_i, nrst_i, ce_i, enable_i, sensorless_i, bad;
  logic                 running_o, zc_o;
  logic [7:0]           duty_i;
  logic [2:0]           hall_i, bemf_cmp_i, pos, bad_code, sector_o;
  bsc_pkg::bsc_bridge_t bridge_o;
  int                   err_count, checked;
  // lead bit 0 red, 1 green, 2 blue
  logic [2:0]           hs_exp [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  logic [2:0]           ls_exp [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};

  bsc_commutator #(.TIMEOUT_CYC(TO)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .enable_i(enable_i), .sensorless_i(sensorless_i), .duty_i(duty_i), .hall_i(hall_i),
    .bemf_cmp_i(bemf_cmp_i), .bridge_o(bridge_o), .sector_o(sector_o),
    .running_o(running_o), .zc_o(zc_o));
  bsc_motor_model motor (.pos_i(pos), .bad_i(bad), .bad_code_i(bad_code), .hall_o(hall_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a missed sector would hang later steps, so the run stops here
  task automatic wait_sector(input logic [2:0] s, input int n);
    int k;
    for (k = 0; k < n && sector_o !== s; k++)
      tick(1);
    chk("sector", {5'h0, s}, {5'h0, sector_o});
    if (sector_o !== s)
      report_and_stop();
  endtask

  // bridge trails the sector by an edge; then wait for a pwm-on cycle
  task automatic chk_bridge(input logic [2:0] s);
    int k;
    tick(2);
    for (k = 0; k < 300 && bridge_o.hs === 3'h0; k++)
      tick(1);
    chk("bridge", {2'h0, hs_exp[s], ls_exp[s]}, {2'h0, bridge_o});
    if (k == 300)
      report_and_stop();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle;
    int k, n;
    n = 0;
    for (k = 0; k < 50; k++)
    begin
      n += (bridge_o !== bsc_pkg::BRIDGE_OFF);
      tick(1);
    end
    chk("on cycles while idle", 8'h0, 8'(n));
    chk("running", 8'h0, {7'h0, running_o});
    $display("test idle done");
  endtask

  task automatic t_hall;
    int i;
    // a valid code seen while idle must pick the starting sector
    pos = 3'h3;
    tick(1);
    enable_i = 1'b1;
    tick(1);
    chk("start sector", 8'h3, {5'h0, sector_o});
    chk("running", 8'h1, {7'h0, running_o});
    for (i = 0; i <= 6; i++)
    begin
      pos = 3'(i % 6);
      wait_sector(3'(i % 6), 4);
      chk_bridge(3'(i % 6));
    end
    $display("test hall sequence done");
  endtask

  task automatic t_pwm;
    logic [7:0] d [3] = '{8'h00, 8'h40, 8'hFF};
    int i, k, n;
    for (i = 0; i < 3; i++)
    begin
      duty_i = d[i];
      tick(600);
      n = 0;
      for (k = 0; k < 256; k++)
      begin
        n += (bridge_o.hs !== 3'h0);
        tick(1);
      end
      chk("pwm on cycles", d[i], 8'(n));
    end
    duty_i = 8'h80;
    $display("test pwm done");
  endtask

  task automatic t_hold;
    logic [2:0] s;
    s = sector_o;
    bad = 1'b1;
    bad_code = 3'h0;
    tick(10);
    chk("sector at 000", {5'h0, s}, {5'h0, sector_o});
    bad_code = 3'h7;
    tick(10);
    chk("sector at 111", {5'h0, s}, {5'h0, sector_o});
    chk("low side held", {5'h0, ls_exp[s]}, {5'h0, bridge_o.ls});
    bad = 1'b0;
    ce_i = 1'b0;
    pos = 3'((s + 1) % 6);
    tick(10);
    chk("frozen sector", {5'h0, s}, {5'h0, sector_o});
    ce_i = 1'b1;
    wait_sector(pos, 4);
    $display("test invalid codes done");
  endtask

  task automatic t_off;
    enable_i = 1'b0;
    tick(3);
    t_idle();
  endtask

  // six zero-cross commutations, then one forced by the timeout
  task automatic t_bemf;
    int i, k;
    logic [2:0] s;
    sensorless_i = 1'b1;
    enable_i = 1'b1;
    tick(3);
    for (i = 0; i < 7; i++)
    begin
      s = sector_o;
      bemf_cmp_i = {3{~s[0]}};
      tick(80);
      if (i < 6)
        bemf_cmp_i = {3{s[0]}};
      for (k = 0; k < 10 && zc_o !== 1'b1 && i < 6; k++)
        tick(1);
      if (i < 6)
        chk("zero cross", 8'h1, {7'h0, zc_o});
      if (k == 10)
        report_and_stop();
      wait_sector(3'((s + 1) % 6), (i < 6) ? 1100 : TO + 100);
    end
    $display("test sensorless done");
  endtask

  initial
  begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    enable_i = 1'b0;
    sensorless_i = 1'b0;
    duty_i = 8'h80;
    bemf_cmp_i = 3'h0;
    pos = 3'h0;
    bad = 1'b0;
    bad_code = 3'h0;
    err_count = 0;
    checked = 0;
    tick(5);
    chk("bridge in reset", 8'h0, {2'h0, bridge_o});
    nrst_i = 1'b1;
    t_idle();
    t_hall();
    t_pwm();
    t_hold();
    t_off();
    t_bemf();
    t_off();
    report_and_stop();
  end
endmodule
